// File: hw/ppss_sequencer.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Function
// [RL1] Timer ticks from 23-bit crystal divider
// [RL2] Reference select: crystal or input vsync
// [RL3] Control bit 7 forces pixel clock low
// [RL4] Bits 5-4 read current state
// [RL5] State sets power, bias, interface pins
// [RL6] New state only after timer expiry
// [RL7] Manual bit drives pins directly
// [RL8] Auto mode targets state from syncs
// [RL9] Steering write sets target state
// [RL10] Counts A: suspend-standby, on-suspend
// [RL11] Counts B: off-standby, standby-off
// [RL12] Counts C: standby-suspend, suspend-on
// [RL13] Steps only between adjacent states
// [RL14] Timer loads count, decrements per tick
// [RL15] State change sets sticky flag
// [RL16] Mask bit resets to one, disabling
// [RL17] Vsync lost after four overflows
module ppss_sequencer
#(
   parameter int DIV_WIDTH = ppss_pkg::PPSS_DIV_WIDTH
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic crystalTick,
   input wire logic inputVsync,
   input wire logic inputHsyncLost,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output ppss_pkg::ppss_pins_s panelPins,
   output logic pixelClockHold,
   output logic irq
);
   import ppss_pkg::*;

   typedef struct packed
   {
      logic [7:0] prescale;
      logic [7:0] control;
      logic [7:0] countsA;
      logic [7:0] countsB;
      logic [7:0] countsC;
      logic [7:0] irqStatus;
      logic [7:0] irqMask;
      logic [DIV_WIDTH-1:0] divider;
      logic vsyncSeen;
      logic busy;
      logic [3:0] timer;
      logic [1:0] nextState;
      logic [1:0] state;
      logic [1:0] target;
      ppss_pins_s pins;
      logic [31:0] rdata;
   } ppss_seq_s;

   ppss_seq_s st_q;
   ppss_seq_s st_d;
   logic vsyncLost;
   logic wrEn;
   logic rdEn;
   logic refTick;
   logic [13:0] addrWord;
   logic addrHit;

   initial
   begin
      if (DIV_WIDTH < 9)
         $error("ppss_sequencer: divider narrower than its loaded byte");
   end

   // Count for the step from one state to its neighbour
   function automatic logic [3:0] step_count(input logic [1:0] from, input logic [1:0] to,
                                              input logic [7:0] a, input logic [7:0] b,
                                              input logic [7:0] c);
      logic [3:0] cnt;
      cnt = 4'h0;
      case ({from, to})
         {PPSS_SUSPEND, PPSS_STANDBY}: cnt = a[7:4]; // [RL10]
         {PPSS_ON, PPSS_SUSPEND}: cnt = a[3:0]; // [RL10]
         {PPSS_OFF, PPSS_STANDBY}: cnt = b[7:4]; // [RL11]
         {PPSS_STANDBY, PPSS_OFF}: cnt = b[3:0]; // [RL11]
         {PPSS_STANDBY, PPSS_SUSPEND}: cnt = c[7:4]; // [RL12]
         {PPSS_SUSPEND, PPSS_ON}: cnt = c[3:0]; // [RL12]
         default: cnt = 4'h0;
      endcase
      return cnt;
   endfunction

   // Pin levels for a sequenced state
   function automatic ppss_pins_s state_pins(input logic [1:0] s);
      ppss_pins_s p;
      p = '0;
      case (s)
         PPSS_OFF: p = '0; // [RL5]
         PPSS_STANDBY: p = '{powerControl: 1'b1, biasEnable: 1'b0, interfaceEnable: 1'b0};
         PPSS_SUSPEND: p = '{powerControl: 1'b1, biasEnable: 1'b0, interfaceEnable: 1'b1};
         PPSS_ON: p = '{powerControl: 1'b1, biasEnable: 1'b1, interfaceEnable: 1'b1};
         default: p = '0;
      endcase
      return p;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Vertical sync loss measurement
   ppss_sync_loss #(
      .CNT_WIDTH(PPSS_VS_CNT_WIDTH),
      .OVF_LIMIT(PPSS_VS_OVF_LIMIT)
   ) u_vsync_loss (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .syncPulse(inputVsync),
      .syncLost(vsyncLost)
   );

   ////////////////////////////////////////////////////////////////////////////
   // APB decode; zero-wait answer, unmapped offset in paddr[13:2] reads zero, any unmapped address errors
   assign addrWord = {paddr[13:2], 2'b00};
   assign addrHit = (paddr[31:14] == '0) && (paddr[1:0] == 2'b00) &&
                    (addrWord == PPSS_ADDR_PRESCALE || addrWord == PPSS_ADDR_CONTROL ||
                     addrWord == PPSS_ADDR_COUNTS_A || addrWord == PPSS_ADDR_COUNTS_B ||
                     addrWord == PPSS_ADDR_COUNTS_C || addrWord == PPSS_ADDR_IRQ_STATUS ||
                     addrWord == PPSS_ADDR_IRQ_MASK);
   assign wrEn = psel && penable && pwrite && addrHit;
   assign rdEn = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addrHit;

   // Tick select: divider underflow or vsync rising edge
   assign refTick = st_q.control[PPSS_CTL_REF_SEL] ? (inputVsync && !st_q.vsyncSeen) // [RL2]
                    : (crystalTick && st_q.divider == '0); // [RL1]

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic for registers, divider, timer and sequencer
   always_comb
   begin
      logic [1:0] goal;
      logic [1:0] stepTo;
      logic stateChanged;
      goal = st_q.target;
      stepTo = st_q.state;
      stateChanged = 1'b0;
      st_d = st_q;
      st_d.vsyncSeen = inputVsync;

      // Divider reloads from the programmed top byte on crystal ticks
      if (crystalTick)
      begin
         if (st_q.divider == '0)
            st_d.divider = {st_q.prescale, {(DIV_WIDTH-8){1'b1}}}; // [RL1]
         else
            st_d.divider = st_q.divider - 1'b1;
      end

      // Target selection by mode; vsync presence is the high state bit
      if (!st_q.control[PPSS_CTL_MANUAL] && st_q.control[PPSS_CTL_AUTO])
         goal = {!vsyncLost, !inputHsyncLost}; // [RL8]
      st_d.target = goal;

      // Sequencer: adjacent steps, each timed by its own count
      if (st_q.busy)
      begin
         if (refTick)
         begin
            if (st_q.timer == 4'h0)
            begin
               st_d.state = st_q.nextState; // [RL6]
               st_d.busy = 1'b0;
               stateChanged = 1'b1;
            end
            else
               st_d.timer = st_q.timer - 4'h1; // [RL14]
         end
      end
      else if (!st_q.control[PPSS_CTL_MANUAL] && goal != st_q.state)
      begin
         stepTo = (goal > st_q.state) ? st_q.state + 2'b01 : st_q.state - 2'b01; // [RL13]
         st_d.nextState = stepTo;
         st_d.timer = step_count(st_q.state, stepTo, st_q.countsA, st_q.countsB,
                                 st_q.countsC); // [RL14]
         st_d.busy = 1'b1;
      end

      // Pin drive: manual bypass or sequenced state
      if (st_q.control[PPSS_CTL_MANUAL])
      begin
         st_d.pins.biasEnable = st_q.control[PPSS_MAN_BIAS]; // [RL7]
         st_d.pins.interfaceEnable = st_q.control[PPSS_MAN_IFACE]; // [RL7]
         st_d.pins.powerControl = st_q.control[PPSS_MAN_PWR]; // [RL7]
      end
      else
         st_d.pins = state_pins(st_d.state); // [RL5]

      // Register writes
      if (wrEn)
      begin
         case (addrWord)
            PPSS_ADDR_PRESCALE: st_d.prescale = pwdata[7:0];
            PPSS_ADDR_CONTROL:
            begin
               st_d.control = {pwdata[7:6], st_q.control[5:4], pwdata[3:0]};
               // Steering write takes effect only with manual and auto off
               if (!pwdata[PPSS_CTL_MANUAL] && !pwdata[PPSS_CTL_AUTO])
                  st_d.target = pwdata[1:0]; // [RL9]
            end
            PPSS_ADDR_COUNTS_A: st_d.countsA = pwdata[7:0]; // [RL10]
            PPSS_ADDR_COUNTS_B: st_d.countsB = pwdata[7:0]; // [RL11]
            PPSS_ADDR_COUNTS_C: st_d.countsC = pwdata[7:0]; // [RL12]
            PPSS_ADDR_IRQ_STATUS: st_d.irqStatus = st_q.irqStatus & ~pwdata[7:0];
            PPSS_ADDR_IRQ_MASK: st_d.irqMask = pwdata[7:0];
            default: st_d.control = st_q.control;
         endcase
      end

      // Sticky flag; a set in the clearing cycle wins
      if (stateChanged)
         st_d.irqStatus[PPSS_IRQ_STATE_CHG] = 1'b1; // [RL15]
      st_d.control[5:4] = st_d.state; // [RL4]

      // Read data captured in the setup cycle
      st_d.rdata = '0;
      if (rdEn)
      begin
         case (addrWord)
            PPSS_ADDR_PRESCALE: st_d.rdata = {24'h000000, st_q.prescale};
            PPSS_ADDR_CONTROL: st_d.rdata = {24'h000000, st_q.control}; // [RL4]
            PPSS_ADDR_COUNTS_A: st_d.rdata = {24'h000000, st_q.countsA};
            PPSS_ADDR_COUNTS_B: st_d.rdata = {24'h000000, st_q.countsB};
            PPSS_ADDR_COUNTS_C: st_d.rdata = {24'h000000, st_q.countsC};
            PPSS_ADDR_IRQ_STATUS: st_d.rdata = {24'h000000, st_q.irqStatus};
            PPSS_ADDR_IRQ_MASK: st_d.rdata = {24'h000000, st_q.irqMask};
            default: st_d.rdata = '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; mask resets to 8'h40, state-change interrupt disabled
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_q <= '0;
         st_q.irqMask <= PPSS_RST_MASK; // [RL16]
      end
      else
         st_q <= st_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign prdata = st_q.rdata;
   assign panelPins = st_q.pins;
   assign pixelClockHold = st_q.control[PPSS_CTL_PCLK_OFF]; // [RL3]
   // Mask bit of zero enables the source
   assign irq = |(st_q.irqStatus & ~st_q.irqMask); // [RL16]
endmodule

// File: inc/ppss_pkg.sv
package ppss_pkg;
   // Register offsets (printed offsets are not word multiples: index times four)
   localparam logic [11:0] PPSS_IDX_PRESCALE = 12'h0d4;
   localparam logic [11:0] PPSS_IDX_CONTROL = 12'h0d5;
   localparam logic [11:0] PPSS_IDX_COUNTS_A = 12'h0d6;
   localparam logic [11:0] PPSS_IDX_COUNTS_B = 12'h0d7;
   localparam logic [11:0] PPSS_IDX_COUNTS_C = 12'h0d8;
   localparam logic [11:0] PPSS_IDX_IRQ_STATUS = 12'h0d9;
   localparam logic [11:0] PPSS_IDX_IRQ_MASK = 12'h0da;
   localparam logic [13:0] PPSS_ADDR_PRESCALE = {PPSS_IDX_PRESCALE, 2'b00};
   localparam logic [13:0] PPSS_ADDR_CONTROL = {PPSS_IDX_CONTROL, 2'b00};
   localparam logic [13:0] PPSS_ADDR_COUNTS_A = {PPSS_IDX_COUNTS_A, 2'b00};
   localparam logic [13:0] PPSS_ADDR_COUNTS_B = {PPSS_IDX_COUNTS_B, 2'b00};
   localparam logic [13:0] PPSS_ADDR_COUNTS_C = {PPSS_IDX_COUNTS_C, 2'b00};
   localparam logic [13:0] PPSS_ADDR_IRQ_STATUS = {PPSS_IDX_IRQ_STATUS, 2'b00};
   localparam logic [13:0] PPSS_ADDR_IRQ_MASK = {PPSS_IDX_IRQ_MASK, 2'b00};
   // Control register fields
   localparam int PPSS_CTL_PCLK_OFF = 7;
   localparam int PPSS_CTL_REF_SEL = 6;
   localparam int PPSS_CTL_STATE_LSB = 4;
   localparam int PPSS_CTL_MANUAL = 3;
   localparam int PPSS_CTL_AUTO = 2;
   localparam int PPSS_MAN_BIAS = 2;
   localparam int PPSS_MAN_IFACE = 1;
   localparam int PPSS_MAN_PWR = 0;
   // Status/mask bit of the power-state-changed event
   localparam int PPSS_IRQ_STATE_CHG = 6;
   // Reset values
   localparam logic [7:0] PPSS_RST_REG = 8'h00;
   localparam logic [7:0] PPSS_RST_MASK = 8'h40;
   // Divider and sync-loss sizing
   localparam int PPSS_DIV_WIDTH = 23;
   localparam int PPSS_VS_CNT_WIDTH = 11;
   localparam int PPSS_VS_OVF_LIMIT = 4;

   typedef enum logic [1:0]
   {
      PPSS_OFF = 2'b00,
      PPSS_STANDBY = 2'b01,
      PPSS_SUSPEND = 2'b10,
      PPSS_ON = 2'b11
   } ppss_state_e;

   typedef struct packed
   {
      logic powerControl;
      logic biasEnable;
      logic interfaceEnable;
   } ppss_pins_s;

   typedef struct packed
   {
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } ppss_apb_req_s;
endpackage

// File: hw/ppss_sync_loss.sv
`timescale 1ns/1ps
// Vertical sync loss detector: period counter overflows four times
module ppss_sync_loss
#(
   parameter int CNT_WIDTH = ppss_pkg::PPSS_VS_CNT_WIDTH,
   parameter int OVF_LIMIT = ppss_pkg::PPSS_VS_OVF_LIMIT
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic syncPulse,
   output logic syncLost
);
   import ppss_pkg::*;

   typedef struct packed
   {
      logic [CNT_WIDTH-1:0] period;
      logic [2:0] overflows;
      logic lost;
   } ppss_loss_s;

   ppss_loss_s st_q;
   ppss_loss_s st_d;

   initial
   begin
      if (CNT_WIDTH < 2 || OVF_LIMIT < 1 || OVF_LIMIT > 7)
         $error("ppss_sync_loss: unsupported parameters");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Count the period; a sync pulse restarts it and clears the loss
   always_comb
   begin
      st_d = st_q;
      if (syncPulse)
      begin
         st_d.period = '0;
         st_d.overflows = 3'h0;
         st_d.lost = 1'b0; // [RL17]
      end
      else
      begin
         st_d.period = st_q.period + 1'b1;
         if (&st_q.period && !st_q.lost)
         begin
            st_d.overflows = st_q.overflows + 3'h1;
            if (st_q.overflows == 3'(OVF_LIMIT - 1))
               st_d.lost = 1'b1; // [RL17]
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign syncLost = st_q.lost;
endmodule

// File: bench/ppss_sequencer_sva.sv
`timescale 1ns/1ps
// Port-level checks of the power sequencer
module ppss_sequencer_chk
   import ppss_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire ppss_pins_s panelPins,
   input wire logic pixelClockHold,
   input wire logic irq
);
   logic [7:0] ctlQ;
   logic maskWrQ;
   logic [1:0] quietQ;
   wire wrCtl = psel && penable && pwrite && paddr == 32'(PPSS_ADDR_CONTROL);
   wire wrMask = psel && penable && pwrite && paddr == 32'(PPSS_ADDR_IRQ_MASK);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////
   // Last control byte; quiet count hides the snap out of manual mode
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctlQ <= 8'h00;
         maskWrQ <= 1'b0;
         quietQ <= 2'h0;
      end
      else
      begin
         if (wrCtl)
            ctlQ <= pwdata[7:0];
         if (wrMask)
            maskWrQ <= 1'b1;
         quietQ <= (ctlQ[3] || (wrCtl && pwdata[3])) ? 2'h0 : quietQ + {1'b0, quietQ != 2'h3};
      end
   end
   ////////////////////////////////////////
   sequence sManWr;
      wrCtl && pwdata[3];
   endsequence
   sequence sSteer;
      wrCtl && pwdata[3:2] == 2'h0 && quietQ == 2'h3;
   endsequence
   chk_reset_off: assert property ($rose(reset_n) |-> panelPins == 3'h0)
      else $error("pins not off after reset");
   chk_bias_power: assert property (quietQ == 2'h3 && panelPins.biasEnable |->
      panelPins.powerControl)
      else $error("bias without power");
   chk_iface_power: assert property (quietQ == 2'h3 && panelPins.interfaceEnable |->
      panelPins.powerControl)
      else $error("interface without power");
   chk_manual_pins: assert property (sManWr |=> ##[0:1]
      panelPins == {ctlQ[0], ctlQ[2], ctlQ[1]})
      else $error("manual pins wrong");
   chk_pclk_hold: assert property (wrCtl |=> ##[0:1] pixelClockHold == ctlQ[7])
      else $error("pixel clock hold wrong");
   chk_one_step: assert property (quietQ == 2'h3 |->
      $countones(panelPins ^ $past(panelPins)) <= 1)
      else $error("state jumped");
   chk_not_immediate: assert property (sSteer |=> $stable(panelPins) [*2])
      else $error("state changed at once");
   chk_irq_masked: assert property (!maskWrQ |-> !irq)
      else $error("irq while masked");
endmodule
bind ppss_sequencer ppss_sequencer_chk i_chk (.ref_clk(ref_clk), .reset_n(reset_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .panelPins(panelPins), .pixelClockHold(pixelClockHold), .irq(irq));

// File: bench/ppss_panel_model.sv
`timescale 1ns/1ps
// Sync source on the panel side; vsync stops dead when not running
module ppss_panel_model
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic vsyncRun,
   input wire logic hsyncOff,
   output logic inputVsync,
   output logic inputHsyncLost
);
   logic [2:0] phaseQ;
   ////////////////////////////////////////
   // One-cycle vsync every eight clocks, short enough for quick steps
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         phaseQ <= 3'h0;
         inputVsync <= 1'b0;
         inputHsyncLost <= 1'b0;
      end
      else
      begin
         phaseQ <= phaseQ + 3'h1;
         inputVsync <= vsyncRun && phaseQ == 3'h7;
         inputHsyncLost <= hsyncOff;
      end
   end
endmodule

// File: bench/panel_power_state_sequencer_tb.sv
`timescale 1ns/1ps
module panel_power_state_sequencer_tb;
   import ppss_pkg::*;
   logic ref_clk, reset_n, crystalTick, psel, penable, pwrite, pready, pslverr, errQ;
   logic inputVsync, inputHsyncLost, pixelClockHold, irq, xtalOn, vsyncRun, hsyncOff;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [7:0] d;
   logic [7:0] cv [3];
   logic [1:0] cur;
   ppss_pins_s panelPins;
   int failures, n_checks, seed, t;
   logic [13:0] addrs [8] = '{PPSS_ADDR_PRESCALE, PPSS_ADDR_CONTROL, PPSS_ADDR_COUNTS_A,
      PPSS_ADDR_COUNTS_B, PPSS_ADDR_COUNTS_C, PPSS_ADDR_IRQ_STATUS, PPSS_ADDR_IRQ_MASK, 14'h36c};
   logic [7:0] rstv [8] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, PPSS_RST_MASK, 8'h0};
   logic [1:0] tgs [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
   ppss_sequencer i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .crystalTick(crystalTick),
      .inputVsync(inputVsync), .inputHsyncLost(inputHsyncLost), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .panelPins(panelPins), .pixelClockHold(pixelClockHold), .irq(irq));
   ppss_panel_model i_panel (.ref_clk(ref_clk), .reset_n(reset_n), .vsyncRun(vsyncRun),
      .hsyncOff(hsyncOff), .inputVsync(inputVsync), .inputHsyncLost(inputHsyncLost));
   ////////////////////////////////////////
   // Clock and a crystal pulse train, solid when the crystal test runs
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
      crystalTick <= xtalOn || ($random(seed) & 1) != 0;
   task print_verdict();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e)
      begin
         failures++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // Bus cycle; request held until pready is seen high
   task apb(input logic w, input logic [13:0] a, input logic [7:0] v);
      int k;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {18'h0, a};
      pwdata <= {24'h0, v};
      @(posedge ref_clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge ref_clk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      rd = prdata;
      errQ = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20)
      begin
         chk(k, 0);
         print_verdict();
      end
   endtask
   ////////////////////////////////////////
   function automatic ppss_pins_s pinsOf(input logic [1:0] s);
      return ppss_pins_s'{s != 2'h0, s == 2'h3, s[1]};
   endfunction
   function automatic logic [3:0] cntOf(input logic [1:0] f, input logic [1:0] n);
      case ({f, n})
         4'h1: return cv[1][7:4];
         4'h4: return cv[1][3:0];
         4'h6: return cv[2][7:4];
         4'h9: return cv[0][7:4];
         4'hb: return cv[2][3:0];
         default: return cv[0][3:0];
      endcase
   endfunction
   // Follow each adjacent step, counting input vsync pulses per step
   task goTo(input logic [1:0] tg, input bit tickChk);
      logic [1:0] nx;
      int k;
      while (cur != tg)
      begin
         nx = cur < tg ? cur + 2'h1 : cur - 2'h1;
         t = 0;
         k = 0;
         while (panelPins !== pinsOf(nx) && k < 60000)
         begin
            @(posedge ref_clk);
            k++;
            t += int'(inputVsync);
         end
         chk(panelPins, pinsOf(nx));
         if (tickChk)
            chk(t >= cntOf(cur, nx) + 1 && t <= cntOf(cur, nx) + 2, 1);
         if (k >= 60000)
            print_verdict();
         cur = nx;
      end
   endtask
   ////////////////////////////////////////
   initial
   begin
      seed = 32'hf5fa;
      {reset_n, psel, penable, pwrite, xtalOn, hsyncOff, crystalTick, cur} = '0;
      {paddr, pwdata, failures, n_checks} = '0;
      vsyncRun = 1'b1;
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b0, addrs[i], 8'h0);
         chk(rd, rstv[i]);
         chk(errQ, i == 7);
      end
      for (int i = 0; i < 3; i++)
      begin
         cv[i] = 8'($random(seed));
         apb(1'b1, addrs[i + 2], cv[i]);
         apb(1'b0, addrs[i + 2], 8'h0);
         chk(rd, cv[i]);
      end
      $display("registers done");
      apb(1'b1, PPSS_ADDR_IRQ_MASK, 8'h00);
      foreach (tgs[i])
      begin
         apb(1'b1, PPSS_ADDR_CONTROL, {6'h10, tgs[i]});
         goTo(tgs[i], 1'b1);
         apb(1'b0, PPSS_ADDR_CONTROL, 8'h0);
         chk(rd[5:4], tgs[i]);
         apb(1'b0, PPSS_ADDR_IRQ_STATUS, 8'h0);
         chk({rd[6], irq}, 2'b11);
         apb(1'b1, PPSS_ADDR_IRQ_STATUS, 8'h40);
         apb(1'b0, PPSS_ADDR_IRQ_STATUS, 8'h0);
         chk({rd[6], irq}, 2'b00);
      end
      $display("steering done");
      for (int i = 0; i < 8; i++)
      begin
         d = {1'($random(seed)), 4'hf, 3'(i)};
         apb(1'b1, PPSS_ADDR_CONTROL, d);
         apb(1'b0, PPSS_ADDR_CONTROL, 8'h0);
         chk(rd, {d[7:6], cur, d[3:0]});
         chk(panelPins, {d[0], d[2], d[1]});
         chk(pixelClockHold, d[7]);
      end
      $display("manual done");
      for (int i = 0; i < 3; i++)
      begin
         cv[i] = 8'h00;
         apb(1'b1, addrs[i + 2], 8'h00);
      end
      apb(1'b1, PPSS_ADDR_CONTROL, 8'h44);
      goTo(2'h3, 1'b1);
      hsyncOff <= 1'b1;
      goTo(2'h2, 1'b1);
      apb(1'b1, PPSS_ADDR_CONTROL, 8'h04);
      xtalOn <= 1'b1;
      vsyncRun <= 1'b0;
      goTo(2'h0, 1'b0);
      $display("auto done");
      print_verdict();
   end
endmodule
